// *** psx_pkg.sv ***
/*
 Package for the status word execution and exception fields block.
 Holds register offsets, field positions, reset values and encodings.
 Assumes a 32-bit APB register bus.
*/
package psx_pkg;

    // Register offsets (byte addresses)
    localparam logic [11:0] PSX_OFF_COMBINED = 12'h000;  // program_status_view
    localparam logic [11:0] PSX_OFF_EXEC     = 12'h004;  // execution_status_view
    localparam logic [11:0] PSX_OFF_EXCNUM   = 12'h008;  // exception_number_view
    localparam logic [11:0] PSX_OFF_CTRL     = 12'h00C;  // sticky fault status

    // Field positions
    localparam int PSX_ISTATE_BIT = 24;
    localparam int PSX_HI_LSB     = 25;
    localparam int PSX_LO_LSB     = 10;
    localparam int PSX_VEC_ISTATE = 0;

    // Reset values
    localparam logic [6:0] PSX_EXCNUM_RST = 7'h00;
    localparam logic [7:0] PSX_BLOCK_RST  = 8'h00;
    localparam logic       PSX_ISTATE_RST = 1'b1;

    // Exception number encodings
    localparam logic [6:0] PSX_EXC_THREAD = 7'h00;
    localparam logic [6:0] PSX_EXC_NMI    = 7'h02;
    localparam logic [6:0] PSX_EXC_FLT_LO = 7'h03;
    localparam logic [6:0] PSX_EXC_FLT_HI = 7'h06;
    localparam logic [6:0] PSX_EXC_SVC    = 7'h0B;
    localparam logic [6:0] PSX_EXC_PSV    = 7'h0E;
    localparam logic [6:0] PSX_EXC_TICK   = 7'h0F;
    localparam logic [6:0] PSX_EXC_IRQ_LO = 7'h10;
    localparam logic [6:0] PSX_EXC_IRQ_HI = 7'h3F;
    localparam logic [6:0] PSX_EXC_HARD   = 7'h03;

    // Execution-state kind
    typedef enum logic [1:0] {
        PSX_ST_NONE = 2'b00,
        PSX_ST_SUSP = 2'b01,
        PSX_ST_COND = 2'b10
    } psx_kind_t;

    // Legal exception number check
    function automatic logic psx_exc_legal(input logic [6:0] n);
        psx_exc_legal = (n == PSX_EXC_THREAD) || (n == PSX_EXC_NMI)
                     || (n >= PSX_EXC_FLT_LO && n <= PSX_EXC_FLT_HI)
                     || (n == PSX_EXC_SVC) || (n == PSX_EXC_PSV) || (n == PSX_EXC_TICK)
                     || (n >= PSX_EXC_IRQ_LO && n <= PSX_EXC_IRQ_HI);
    endfunction

endpackage

// *** psx_view_if.sv ***
/*
 Interface carrying the assembled status fields from the core to the read mux.
 Assumes a single clock domain; pure wires.
*/
`timescale 1ns/1ps
interface psx_view_if;
    logic       istate;
    logic [7:0] blk;
    logic [6:0] excnum;
    logic       fault;
    modport core (output istate, output blk, output excnum, output fault);
    modport view (input istate, input blk, input excnum, input fault);
endinterface

// *** psx_rdmux.sv ***
/*
 Read-data assembly for the status views over APB.
 Assumes fields arrive from the core through psx_view_if.
*/
`timescale 1ns/1ps
module psx_rdmux
    import psx_pkg::*;
(
    // Field source
    psx_view_if.view          vw,
    // Address
    input  wire logic [11:0]  addr,
    // Read word
    output logic [31:0]       rdata,
    output logic              hit
);

    // Views; reserved 23:16 and 9:7 stay zero, istate only in combined/exec
    always_comb
    begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (addr)
            PSX_OFF_COMBINED, PSX_OFF_EXEC:
            begin
                rdata[PSX_ISTATE_BIT]             = vw.istate;
                rdata[PSX_HI_LSB +: 2]            = vw.blk[1:0];
                rdata[PSX_LO_LSB +: 6]            = vw.blk[7:2];
                if (addr == PSX_OFF_COMBINED)
                    rdata[6:0] = vw.excnum;
            end
            PSX_OFF_EXCNUM: rdata[6:0] = vw.excnum;
            PSX_OFF_CTRL:   rdata[0]   = vw.fault;
            default:        hit = 1'b0;
        endcase
    end

endmodule

// *** psx_status.sv ***
/*
 Execution-state and exception-number fields of the program status word.
 Assumes the core sequencer gives one-cycle event pulses and an APB master.
*/
// Behaviour
// - Exchange branches load istate from target
// - Exception return reloads istate from stacked word
// - Entry or reset loads istate from vector
// - Executing with istate clear raises fault/lockup
// - Bits 23:16, 9:7 reserved, read zero
// - Bits 15:10, 26:25 hold block state
// - Interrupted multi-transfer records next register
// - Resume transfer at recorded register, in thread mode only
// - Suspended state keeps 11:10, 26:25 zero
// - Up to four conditional instructions tracked
// - Conditions are base or its inverse
// - Bits 6:0 report exception number in combined/excnum views, read zero in exec view
// - istate shown only in combined/exec views
`timescale 1ns/1ps
module psx_status
    import psx_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Branch with exchange
    input  wire logic        xchg_branch,
    input  wire logic [31:0] xchg_target,
    // Exception entry and return
    input  wire logic        exc_entry,
    input  wire logic [6:0]  exc_entry_num,
    input  wire logic [31:0] vector_value,
    input  wire logic        exc_return,
    input  wire logic [31:0] stacked_status,
    input  wire logic [6:0]  exc_return_num,
    // Multi-register transfer
    input  wire logic        xfer_interrupt,
    input  wire logic [3:0]  xfer_next_reg,
    input  wire logic        xfer_resume_req,
    // Conditional block
    input  wire logic        cond_prefix,
    input  wire logic [7:0]  cond_prefix_bits,
    input  wire logic        instr_retire,
    // Execution request and outcome
    input  wire logic        instr_issue,
    output logic             exec_allow,
    output logic             fault_req,
    output logic             lockup,
    output logic             resume_valid,
    output logic [3:0]       resume_reg,
    output logic             cond_active,
    output logic [3:0]       cond_code
);

    // State of the block
    typedef struct packed {
        logic        istate;
        psx_kind_t   kind;
        logic [7:0]  blk;
        logic [6:0]  excnum;
        logic        fault;
        logic        lock;
        logic        resume;
        logic [3:0]  rreg;
        logic        boot;
        logic [31:0] rdata;
    } psx_state_t;

    psx_state_t st_r;
    psx_state_t st_nxt;

    psx_view_if vw ();
    logic [31:0] mux_rdata;
    logic        mux_hit;

    assign vw.istate = st_r.istate;
    assign vw.blk    = st_r.blk;
    assign vw.excnum = st_r.excnum;
    assign vw.fault  = st_r.fault;

    psx_rdmux u_rdmux (
        .vw    (vw),
        .addr  (paddr),
        .rdata (mux_rdata),
        .hit   (mux_hit)
    );

    // Access phase completes at once; no wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mux_hit;
    assign prdata  = st_r.rdata;

    // Block-state condition: base in 7:5, mask in 4:0 with low bit of cond from blk[4]
    function automatic logic [7:0] psx_cond_advance(input logic [7:0] b);
        if (b[3:0] == 4'h8 || b[3:0] == 4'h0)
            psx_cond_advance = 8'h00;
        else
            psx_cond_advance = {b[7:5], b[4:0] << 1};
    endfunction

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // Read data latched in setup so it is stable in the access phase
        if (psel && !penable && !pwrite)
            st_nxt.rdata = mux_rdata;
        // Writes to all views are ignored: fields are hardware-owned
        // Clearing the sticky fault bit is the only writable control
        if (psel && penable && pwrite && paddr == PSX_OFF_CTRL && pwdata[0])
            st_nxt.fault = 1'b0;
        // First cycle after reset: fetch istate from vector bit 0
        if (st_r.boot)
        begin
            st_nxt.boot   = 1'b0;
            st_nxt.istate = vector_value[PSX_VEC_ISTATE];
        end
        // Execute attempt with istate clear faults, or locks if already at hard fault or NMI
        st_nxt.resume = 1'b0;
        if (instr_issue && !st_r.istate && !st_r.lock)
        begin
            if (st_r.excnum == PSX_EXC_HARD || st_r.excnum == PSX_EXC_NMI)
                st_nxt.lock = 1'b1;
            else
                st_nxt.fault = 1'b1;
        end
        else if (instr_retire && st_r.kind == PSX_ST_COND)
        begin
            st_nxt.blk = psx_cond_advance(st_r.blk);
            if (psx_cond_advance(st_r.blk) == 8'h00)
                st_nxt.kind = PSX_ST_NONE;
        end
        // Conditional prefix opens a block of up to four instructions
        if (cond_prefix)
        begin
            st_nxt.kind = PSX_ST_COND;
            st_nxt.blk  = cond_prefix_bits;
        end
        // Interrupted multi-transfer: record next register, low bits zero
        if (xfer_interrupt)
        begin
            st_nxt.kind = PSX_ST_SUSP;
            st_nxt.blk  = {xfer_next_reg, 2'b00, 2'b00};
        end
        // Resume the suspended transfer at the recorded register, only when in thread mode
        if (xfer_resume_req && st_r.kind == PSX_ST_SUSP && st_r.excnum == PSX_EXC_THREAD)
        begin
            st_nxt.resume = 1'b1;
            st_nxt.rreg   = st_r.blk[7:4];
            st_nxt.kind   = PSX_ST_NONE;
            st_nxt.blk    = PSX_BLOCK_RST;
        end
        // Exchange branches take istate from target bit 0
        if (xchg_branch)
            st_nxt.istate = xchg_target[0];
        // Exception entry: istate from vector, new number only if it is legal
        if (exc_entry)
        begin
            st_nxt.istate = vector_value[PSX_VEC_ISTATE];
            if (psx_exc_legal(exc_entry_num))
                st_nxt.excnum = exc_entry_num;
        end
        // Exception return: restore istate and execution state from stacked word
        if (exc_return)
        begin
            st_nxt.istate = stacked_status[PSX_ISTATE_BIT];
            st_nxt.blk    = {stacked_status[PSX_LO_LSB +: 6],
                             stacked_status[PSX_HI_LSB +: 2]};
            if (stacked_status[PSX_HI_LSB +: 2] == 2'b00
                && stacked_status[PSX_LO_LSB +: 2] == 2'b00
                && stacked_status[PSX_LO_LSB + 2 +: 4] != 4'h0)
                st_nxt.kind = PSX_ST_SUSP;
            else if (stacked_status[PSX_LO_LSB +: 6] != 6'h00
                     || stacked_status[PSX_HI_LSB +: 2] != 2'b00)
                st_nxt.kind = PSX_ST_COND;
            else
                st_nxt.kind = PSX_ST_NONE;
            if (psx_exc_legal(exc_return_num))
                st_nxt.excnum = exc_return_num;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r        <= '0;
            st_r.istate <= PSX_ISTATE_RST;
            st_r.excnum <= PSX_EXCNUM_RST;
            st_r.blk    <= PSX_BLOCK_RST;
            st_r.kind   <= PSX_ST_NONE;
            st_r.boot   <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign exec_allow   = st_r.istate && !st_r.lock;
    assign fault_req    = st_r.fault;
    assign lockup       = st_r.lock;
    assign resume_valid = st_r.resume;
    assign resume_reg   = st_r.rreg;
    assign cond_active  = (st_r.kind == PSX_ST_COND);
    // Condition is base with low bit from the mask's top: base or its inverse
    assign cond_code    = {st_r.blk[7:5], st_r.blk[4]};

    // Assertions
    AST_XCHG: assert property (@(posedge clk_sys) disable iff (!rst_b)
        xchg_branch && !exc_entry && !exc_return |=> st_r.istate == $past(xchg_target[0]))
        else $error("istate not loaded from branch target");
    AST_RET: assert property (@(posedge clk_sys) disable iff (!rst_b)
        exc_return |=> st_r.istate == $past(stacked_status[24]))
        else $error("istate not restored on return");
    AST_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        exc_entry && !exc_return |=> st_r.istate == $past(vector_value[0]))
        else $error("istate not loaded from vector");
    AST_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        instr_issue && !st_r.istate |=> fault_req || lockup)
        else $error("no fault on clear istate");
    AST_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        psel && penable && !pwrite |-> prdata[23:16] == 8'h00 && prdata[9:7] == 3'h0)
        else $error("reserved bits not zero");
    AST_SUSP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        xfer_interrupt && !xfer_resume_req && !exc_return
        |=> st_r.blk[7:4] == $past(xfer_next_reg))
        else $error("next register not recorded");
    AST_RESUME: assert property (@(posedge clk_sys) disable iff (!rst_b)
        resume_valid |-> resume_reg == $past(st_r.blk[7:4]))
        else $error("resume register wrong");
    AST_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r.kind == PSX_ST_SUSP |-> st_r.blk[3:0] == 4'h0)
        else $error("suspended state low bits nonzero");
    AST_EXCNUM: assert property (@(posedge clk_sys) disable iff (!rst_b)
        psx_exc_legal(st_r.excnum))
        else $error("illegal exception number");
    AST_WRIGN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        psel && penable && pwrite && !exc_entry && !exc_return |=> $stable(st_r.excnum))
        else $error("write changed exception number");
    // An entry with a reserved number keeps the current number
    AST_EXCKEEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        exc_entry && !exc_return && !psx_exc_legal(exc_entry_num) |=> $stable(st_r.excnum))
        else $error("reserved exception number taken");
    // Lockup is left only through reset
    AST_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_b)
        lockup |=> lockup)
        else $error("lockup released without reset");
    // Retiring the last instruction of a block closes it
    AST_CONDEND: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cond_active && instr_retire && st_r.blk[2:0] == 3'b000 && !instr_issue
        && !cond_prefix && !xfer_interrupt && !exc_return |=> !cond_active)
        else $error("conditional block not closed");

endmodule

// *** psx_status_test.sv ***
/*
 Self-checking bench for psx_status: APB view accesses and core event pulses.
 Assumes psx_pkg is compiled first and the design carries its own assertions.
*/
`timescale 1ns/1ps
module psx_status_test;
    import psx_pkg::*;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, xchg_target, vector_value, stacked_status, q;
    logic        xchg_branch, exc_entry, exc_return, xfer_interrupt, xfer_resume_req;
    logic        cond_prefix, instr_retire, instr_issue, e;
    logic [6:0]  exc_entry_num, exc_return_num;
    logic [3:0]  xfer_next_reg, resume_reg, cond_code, rr, cc;
    logic [7:0]  cond_prefix_bits;
    logic        exec_allow, fault_req, lockup, resume_valid, cond_active;
    logic        rv1, rv2, fq, lk, ea, ca;
    int          err_count, check_count, i;
    logic [6:0]  exc_tab [8] = '{7'h02, 7'h03, 7'h06, 7'h0B, 7'h0E, 7'h0F, 7'h10, 7'h3F};
    logic [3:0]  cc_tab [3] = '{4'h0, 4'h1, 4'h0};

    psx_status DUT (
        .clk_sys          (clk_sys),          .rst_b            (rst_b),
        .psel             (psel),             .penable          (penable),
        .pwrite           (pwrite),           .paddr            (paddr),
        .pwdata           (pwdata),           .prdata           (prdata),
        .pready           (pready),           .pslverr          (pslverr),
        .xchg_branch      (xchg_branch),      .xchg_target      (xchg_target),
        .exc_entry        (exc_entry),        .exc_entry_num    (exc_entry_num),
        .vector_value     (vector_value),     .exc_return       (exc_return),
        .stacked_status   (stacked_status),   .exc_return_num   (exc_return_num),
        .xfer_interrupt   (xfer_interrupt),   .xfer_next_reg    (xfer_next_reg),
        .xfer_resume_req  (xfer_resume_req),  .cond_prefix      (cond_prefix),
        .cond_prefix_bits (cond_prefix_bits), .instr_retire     (instr_retire),
        .instr_issue      (instr_issue),      .exec_allow       (exec_allow),
        .fault_req        (fault_req),        .lockup           (lockup),
        .resume_valid     (resume_valid),     .resume_reg       (resume_reg),
        .cond_active      (cond_active),      .cond_code        (cond_code)
    );

    // Clock at 250 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task end_of_test;
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge clk_sys);
    endtask

    // Read a view and compare the masked word
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q & m, exp);
    endtask

    // One-cycle event strobe, then sample outputs on two falling edges
    task pulse(input int k);
        case (k)
            0: xchg_branch <= 1'b1;
            1: exc_entry <= 1'b1;
            2: exc_return <= 1'b1;
            3: xfer_interrupt <= 1'b1;
            4: xfer_resume_req <= 1'b1;
            5: cond_prefix <= 1'b1;
            6: instr_retire <= 1'b1;
            default: instr_issue <= 1'b1;
        endcase
        @(posedge clk_sys);
        {xchg_branch, exc_entry, exc_return, xfer_interrupt} <= 4'h0;
        {xfer_resume_req, cond_prefix, instr_retire, instr_issue} <= 4'h0;
        @(negedge clk_sys);
        rv1 = resume_valid;
        rr  = resume_reg;
        @(negedge clk_sys);
        {rv2, fq, lk, ea, ca, cc} = {resume_valid, fault_req, lockup, exec_allow, cond_active,
                                     cond_code};
        @(posedge clk_sys);
    endtask

    // Main sequence
    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {xchg_branch, exc_entry, exc_return, xfer_interrupt} = '0;
        {xfer_resume_req, cond_prefix, instr_retire, instr_issue} = '0;
        {xchg_target, stacked_status, exc_entry_num, exc_return_num} = '0;
        {xfer_next_reg, cond_prefix_bits} = '0;
        vector_value = 32'h0000_0001;
        err_count = 0;
        check_count = 0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(PSX_OFF_COMBINED, 32'hFFFF_FFFF, 32'h0100_0000);
        rd(PSX_OFF_EXEC, 32'hFFFF_FFFF, 32'h0100_0000);
        rd(PSX_OFF_EXCNUM, 32'hFFFF_FFFF, 32'h0000_0000);
        for (i = 0; i < 3; i++)
            apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
        rd(PSX_OFF_COMBINED, 32'hFFFF_FFFF, 32'h0100_0000);
        chk(32'(e), 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        // Legal exception numbers (range ends and single values, not thread), then illegal ones left out
        for (i = 0; i < 8; i++)
        begin
            exc_entry_num <= exc_tab[i];
            pulse(1);
            rd(PSX_OFF_EXCNUM, 32'h0000_007F, 32'(exc_tab[i]));
        end
        exc_entry_num <= 7'h07;
        pulse(1);
        rd(PSX_OFF_EXCNUM, 32'h0000_007F, 32'h0000_003F);
        exc_entry_num <= 7'h40;
        pulse(1);
        rd(PSX_OFF_EXCNUM, 32'h0000_007F, 32'h0000_003F);
        stacked_status <= 32'h0100_0000;
        pulse(2);
        rd(PSX_OFF_COMBINED, 32'hFFFF_FFFF, 32'h0100_0000);
        // Entry with a clear vector bit, then an execution attempt
        vector_value  <= 32'h0000_0000;
        exc_entry_num <= PSX_EXC_SVC;
        pulse(1);
        rd(PSX_OFF_COMBINED, 32'hFFFF_FFFF, 32'h0000_000B);
        pulse(7);
        chk(32'({fq, lk, ea}), 32'h0000_0004);
        rd(PSX_OFF_CTRL, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, PSX_OFF_CTRL, 32'h0000_0001);
        rd(PSX_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
        // Exchange branches and stacked reload in both directions
        for (i = 0; i < 4; i++)
        begin
            xchg_target    <= 32'(i[0] ^ 1'b1);
            stacked_status <= {7'h00, ~i[0], 24'h00_0000};
            pulse(i < 2 ? 0 : 2);
            rd(PSX_OFF_COMBINED, 32'h0100_0000, {7'h00, ~i[0], 24'h00_0000});
        end
        // Suspended multi-register transfer and its resume; istate is clear here
        xfer_next_reg <= 4'h5;
        pulse(3);
        rd(PSX_OFF_COMBINED, 32'h0680_FF80, 32'h0000_5000);
        rd(PSX_OFF_EXEC, 32'h0700_FC00, 32'h0000_5000);
        pulse(4);
        chk(32'({rv1, rr, rv2}), 32'h0000_002A);
        // Conditional block of four instructions
        cond_prefix_bits <= 8'h15;
        pulse(5);
        rd(PSX_OFF_COMBINED, 32'h0600_FC00, 32'h0200_1400);
        chk(32'({ca, cc}), 32'h0000_0011);
        for (i = 0; i < 4; i++)
        begin
            pulse(6);
            chk(32'({ca, cc}), i < 3 ? 32'({1'b1, cc_tab[i]}) : 32'h0000_0000);
        end
        // Clear state bit inside a hard fault handler locks up
        exc_entry_num <= PSX_EXC_HARD;
        pulse(1);
        pulse(7);
        chk(32'({lk, ea}), 32'h0000_0002);
        // Reset in mid-run drops lockup; boot reloads istate from a clear vector bit
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'({lockup, fault_req, exec_allow}), 32'h0000_0000);
        @(posedge clk_sys);
        rd(PSX_OFF_COMBINED, 32'hFFFF_FFFF, 32'h0000_0000);
        end_of_test();
    end
endmodule
